// *** logic/imc_params.svh ***
`ifndef IMC_PARAMS_SVH
`define IMC_PARAMS_SVH

// ****************************************************************
// register map
// ****************************************************************
`define IMC_CMD_ADDR        32'h40044004
`define IMC_STAT_ADDR       32'h40044008

// ****************************************************************
// command word fields
// ****************************************************************
`define IMC_CMD_START_BIT   0
`define IMC_CMD_STOP_BIT    1
`define IMC_CMD_SRST_BIT    2
`define IMC_CMD_RECOMP_LSB  4
`define IMC_CMD_WOFF_LSB    8
`define IMC_CMD_WON_LSB     12

// ****************************************************************
// status word fields
// ****************************************************************
`define IMC_STAT_RUN_BIT    0
`define IMC_STAT_STOP_BIT   1
`define IMC_STAT_PEND_LSB   4
`define IMC_STAT_WATCH_LSB  8
`define IMC_STAT_REJ_LSB    12

// ****************************************************************
// reset values and counts
// ****************************************************************
`define IMC_NUM_REGIONS     4
`define IMC_WATCH_RST       4'hF
`define IMC_PEND_RST        4'h0
`define IMC_RDATA_RST       32'h00000000

`endif

// *** logic/imc_pkg.sv ***
`include "imc_params.svh"

package imc_pkg;

	typedef enum logic [1:0] {
		IMC_ST_IDLE = 2'b00,
		IMC_ST_RUN  = 2'b01,
		IMC_ST_STOP = 2'b10
	} imc_state_e;

	typedef struct packed {
		logic       start;
		logic       stop;
		logic       soft_rst;
		logic [3:0] recompute;
		logic [3:0] watch_off;
		logic [3:0] watch_on;
	} imc_cmd_s;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [31:0] addr;
		logic [31:0] wdata;
	} imc_bus_s;

	function automatic logic imc_hit(input logic [31:0] addr,
		input logic [31:0] base);
		imc_hit = (addr == base);
	endfunction

endpackage

// *** logic/imc_cmd_decode.sv ***
`timescale 1ns/1ps
`include "imc_params.svh"

module imc_cmd_decode
	import imc_pkg::*;
(
	input  wire imc_bus_s i_bus,
	output imc_cmd_s      o_cmd
);

	logic take;

	// only a write to the command address acts; zeros and spare bits
	// have no effect
	assign take = i_bus.wr && imc_hit(i_bus.addr, `IMC_CMD_ADDR);

	always_comb begin
		o_cmd = '0;
		if (take) begin
			o_cmd.start     = i_bus.wdata[`IMC_CMD_START_BIT];
			o_cmd.stop      = i_bus.wdata[`IMC_CMD_STOP_BIT];
			o_cmd.soft_rst  = i_bus.wdata[`IMC_CMD_SRST_BIT];
			o_cmd.recompute = i_bus.wdata[`IMC_CMD_RECOMP_LSB +: 4];
			o_cmd.watch_off = i_bus.wdata[`IMC_CMD_WOFF_LSB +: 4];
			o_cmd.watch_on  = i_bus.wdata[`IMC_CMD_WON_LSB +: 4];
		end
	end

endmodule

// *** logic/imc_region_ctl.sv ***
`timescale 1ns/1ps
`include "imc_params.svh"

module imc_region_ctl
	import imc_pkg::*;
#(
	parameter int NREG = `IMC_NUM_REGIONS
) (
	input  wire logic            i_clk,
	input  wire logic            i_rst_b,
	input  wire logic            i_soft_rst,
	input  wire logic [NREG-1:0] i_watch_off,
	input  wire logic [NREG-1:0] i_watch_on,
	input  wire logic [NREG-1:0] i_recompute,
	input  wire logic [NREG-1:0] i_recomp_done,
	output logic      [NREG-1:0] o_watch,
	output logic      [NREG-1:0] o_pend,
	output logic      [NREG-1:0] o_refused
);

	logic [NREG-1:0] watch_r;
	logic [NREG-1:0] watch_nxt;
	logic [NREG-1:0] pend_r;
	logic [NREG-1:0] accept;

	// ****************************************************************
	// per-region watch state
	// ****************************************************************
	// off wins over on when both bits of one region are written
	always_comb begin
		watch_nxt = (watch_r | i_watch_on) & ~i_watch_off;
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			watch_r <= `IMC_WATCH_RST;
		end else if (i_soft_rst) begin
			watch_r <= `IMC_WATCH_RST;
		end else begin
			watch_r <= watch_nxt;
		end
	end

	// ****************************************************************
	// recompute requests
	// ****************************************************************
	// only honoured while the region is not watched
	assign accept    = i_recompute & ~watch_r;
	assign o_refused = i_recompute & watch_r;

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pend_r <= `IMC_PEND_RST;
		end else if (i_soft_rst) begin
			pend_r <= `IMC_PEND_RST;
		end else begin
			// a new request in the done cycle stays pending
			pend_r <= (pend_r & ~i_recomp_done) | accept;
		end
	end

	assign o_watch = watch_r;
	assign o_pend  = pend_r;

endmodule

// *** logic/imc_top.sv ***
// Notes on behaviour
// - writing one to bit 0 starts the monitor controller
// - writing one to bit 1 stops it and ends any region in progress
// - writing one to bit 2 returns the whole controller to reset state
// - bits 7..4 recompute a region digest, only while its watch is off
// - bit i of 11..8 turns monitoring of region i off
// - bit i of 15..12 turns monitoring of region i on
// - every region is watched after reset until switched off
`timescale 1ns/1ps
`include "imc_params.svh"

module imc_top
	import imc_pkg::*;
#(
	parameter int NREG = `IMC_NUM_REGIONS
) (
	input  wire logic            I_MCLK,
	input  wire logic            I_RST_B,
	input  wire logic [31:0]     I_ADDR,
	input  wire logic [31:0]     I_WDATA,
	input  wire logic            I_WR,
	input  wire logic            I_RD,
	output logic      [31:0]     O_RDATA,
	input  wire logic            I_REGION_BUSY,
	input  wire logic [NREG-1:0] I_RECOMP_DONE,
	output logic                 O_MON_EN,
	output logic                 O_TERMINATE,
	output logic                 O_SOFT_RESET,
	output logic      [NREG-1:0] O_WATCH,
	output logic      [NREG-1:0] O_RECOMP_REQ
);

	// ****************************************************************
	// declarations
	// ****************************************************************
	imc_bus_s        bus;
	imc_cmd_s        cmd;
	imc_state_e      state_r;
	imc_state_e      state_nxt;
	logic            restart_r;
	logic            restart_nxt;
	logic            srst_pulse_r;
	logic [31:0]     rdata_r;
	logic [31:0]     status;
	logic [NREG-1:0] watch;
	logic [NREG-1:0] pend;
	logic [NREG-1:0] refused;
	logic [NREG-1:0] rej_r;
	logic            stat_rd;

	assign bus.wr    = I_WR;
	assign bus.rd    = I_RD;
	assign bus.addr  = I_ADDR;
	assign bus.wdata = I_WDATA;

	// ****************************************************************
	// command decode
	// ****************************************************************
	// spare bits and zeros ignored
	imc_cmd_decode u_decode (
		.i_bus (bus),
		.o_cmd (cmd)
	);

	// ****************************************************************
	// region bookkeeping
	// ****************************************************************
	imc_region_ctl #(
		.NREG (NREG)
	) u_region (
		.i_clk         (I_MCLK),
		.i_rst_b       (I_RST_B),
		.i_soft_rst    (cmd.soft_rst),
		.i_watch_off   (cmd.watch_off[NREG-1:0]),
		.i_watch_on    (cmd.watch_on[NREG-1:0]),
		.i_recompute   (cmd.recompute[NREG-1:0]),
		.i_recomp_done (I_RECOMP_DONE),
		.o_watch       (watch),
		.o_pend        (pend),
		.o_refused     (refused)
	);

	// ****************************************************************
	// controller state
	// ****************************************************************
	// stop wins over start written in the same word, so a careless
	// write of both never leaves the engine running
	always_comb begin
		state_nxt   = state_r;
		restart_nxt = restart_r;
		unique case (state_r)
			IMC_ST_IDLE: begin
				if (cmd.start && !cmd.stop) begin
					state_nxt = IMC_ST_RUN;
				end
			end
			IMC_ST_RUN: begin
				if (cmd.stop) begin
					if (I_REGION_BUSY) begin
						state_nxt = IMC_ST_STOP;
					end else begin
						state_nxt = IMC_ST_IDLE;
					end
				end
			end
			IMC_ST_STOP: begin
				// a start during termination is kept and acted on once
				// the engine has let go of the region
				if (cmd.stop) begin
					restart_nxt = 1'b0;
				end else if (cmd.start) begin
					restart_nxt = 1'b1;
				end
				// the kept start is consumed here, so it is read before
				// being cleared
				if (!I_REGION_BUSY) begin
					if (restart_nxt) begin
						state_nxt = IMC_ST_RUN;
					end else begin
						state_nxt = IMC_ST_IDLE;
					end
					restart_nxt = 1'b0;
				end
			end
			default: begin
				state_nxt   = IMC_ST_IDLE;
				restart_nxt = 1'b0;
			end
		endcase
	end

	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			state_r <= IMC_ST_IDLE;
		end else if (cmd.soft_rst) begin
			state_r <= IMC_ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			restart_r <= 1'b0;
		end else if (cmd.soft_rst) begin
			restart_r <= 1'b0;
		end else begin
			restart_r <= restart_nxt;
		end
	end

	// ****************************************************************
	// soft reset pulse to the engine
	// ****************************************************************
	// engine told to drop its work too
	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			srst_pulse_r <= 1'b0;
		end else begin
			srst_pulse_r <= cmd.soft_rst;
		end
	end

	// ****************************************************************
	// refused recompute record
	// ****************************************************************
	// sticky; cleared by a status read, but a refusal in that very
	// cycle survives the clear
	assign stat_rd = I_RD && imc_hit(I_ADDR, `IMC_STAT_ADDR);

	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			rej_r <= '0;
		end else if (cmd.soft_rst) begin
			rej_r <= '0;
		end else if (stat_rd) begin
			rej_r <= refused;
		end else begin
			rej_r <= rej_r | refused;
		end
	end

	// ****************************************************************
	// status word and read port
	// ****************************************************************
	always_comb begin
		status = '0;
		status[`IMC_STAT_RUN_BIT]            = (state_r == IMC_ST_RUN);
		status[`IMC_STAT_STOP_BIT]           = (state_r == IMC_ST_STOP);
		status[`IMC_STAT_PEND_LSB  +: NREG]  = pend;
		status[`IMC_STAT_WATCH_LSB +: NREG]  = watch;
		status[`IMC_STAT_REJ_LSB   +: NREG]  = rej_r;
	end

	// command word and unmapped addresses read zero
	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			rdata_r <= `IMC_RDATA_RST;
		end else if (stat_rd) begin
			rdata_r <= status;
		end else begin
			rdata_r <= `IMC_RDATA_RST;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign O_RDATA      = rdata_r;
	assign O_MON_EN     = (state_r == IMC_ST_RUN);
	// termination held until the region is released
	assign O_TERMINATE  = (state_r == IMC_ST_STOP);
	assign O_SOFT_RESET = srst_pulse_r;
	assign O_WATCH      = watch;
	assign O_RECOMP_REQ = pend;

endmodule

// *** sim/imc_top_properties.sv ***
`timescale 1ns/1ps
`include "imc_params.svh"

module imc_top_properties #(
	parameter int NREG = 4
) (
	input wire logic            I_MCLK,
	input wire logic            I_RST_B,
	input wire logic [31:0]     I_ADDR,
	input wire logic [31:0]     I_WDATA,
	input wire logic            I_WR,
	input wire logic            I_RD,
	input wire logic [31:0]     O_RDATA,
	input wire logic            I_REGION_BUSY,
	input wire logic [NREG-1:0] I_RECOMP_DONE,
	input wire logic            O_MON_EN,
	input wire logic            O_TERMINATE,
	input wire logic            O_SOFT_RESET,
	input wire logic [NREG-1:0] O_WATCH,
	input wire logic [NREG-1:0] O_RECOMP_REQ
);
	logic            wr_cmd;
	logic [NREG-1:0] w_off;
	logic [NREG-1:0] w_on;
	logic [NREG-1:0] rc_ok;
	assign wr_cmd = I_WR && I_ADDR == `IMC_CMD_ADDR;
	assign w_off = I_WDATA[8+:NREG];
	assign w_on = I_WDATA[12+:NREG] & ~w_off;
	assign rc_ok = I_WDATA[4+:NREG] & ~O_WATCH;
	default clocking @(posedge I_MCLK);
	endclocking
	default disable iff (!I_RST_B);

	// a start while stopping is deferred, hence the terminate guard
	a_start_runs: assert property (
		wr_cmd && I_WDATA[2:0] == 3'h1 && !O_TERMINATE |=> O_MON_EN)
		else $error("start ignored");
	a_stop_halts: assert property (wr_cmd && I_WDATA[1] |=> !O_MON_EN)
		else $error("stop ignored");
	a_stop_ends: assert property (
		wr_cmd && I_WDATA[2:1] == 2'h1 && O_MON_EN && I_REGION_BUSY
		|=> O_TERMINATE) else $error("region not ended");
	a_end_drops: assert property (
		O_TERMINATE && !I_REGION_BUSY && !wr_cmd |=> !O_TERMINATE)
		else $error("terminate stuck");
	a_soft_reset: assert property (wr_cmd && I_WDATA[2] |=> O_SOFT_RESET
		&& !O_MON_EN && &O_WATCH && O_RECOMP_REQ == '0)
		else $error("soft reset incomplete");
	a_watch_off: assert property (wr_cmd && !I_WDATA[2]
		|=> (O_WATCH & $past(w_off)) == '0) else $error("watch not off");
	a_watch_on: assert property (wr_cmd && !I_WDATA[2]
		|=> (O_WATCH & $past(w_on)) == $past(w_on))
		else $error("watch not on");
	a_recomp_refuse: assert property (
		(O_RECOMP_REQ & ~$past(O_RECOMP_REQ) & $past(O_WATCH)) == '0)
		else $error("recompute on watched region");
	a_recomp_take: assert property (wr_cmd && I_WDATA[2:1] == 2'h0
		|=> (O_RECOMP_REQ & $past(rc_ok)) == $past(rc_ok))
		else $error("recompute lost");
	a_done_clears: assert property (!wr_cmd
		|=> (O_RECOMP_REQ & $past(I_RECOMP_DONE)) == '0)
		else $error("pending not cleared");
	a_rdata_zero: assert property (
		!I_RD || I_ADDR == `IMC_CMD_ADDR |=> O_RDATA == '0)
		else $error("read data not zero");
	a_srst_cause: assert property (
		!(wr_cmd && I_WDATA[`IMC_CMD_SRST_BIT]) |=> !O_SOFT_RESET)
		else $error("soft reset pulse without a write");
endmodule

bind imc_top imc_top_properties #(.NREG(NREG)) u_props (
	.I_MCLK(I_MCLK), .I_RST_B(I_RST_B), .I_ADDR(I_ADDR),
	.I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
	.I_REGION_BUSY(I_REGION_BUSY), .I_RECOMP_DONE(I_RECOMP_DONE),
	.O_MON_EN(O_MON_EN), .O_TERMINATE(O_TERMINATE),
	.O_SOFT_RESET(O_SOFT_RESET), .O_WATCH(O_WATCH),
	.O_RECOMP_REQ(O_RECOMP_REQ)
);

// *** sim/integrity_monitor_control_test.sv ***
`timescale 1ns/1ps
`include "imc_params.svh"

module integrity_monitor_control_test;
	typedef struct packed {
		logic [31:0] d;
		logic        en;
		logic [3:0]  w;
		logic [3:0]  q;
	} imc_row_s;
	// rows run in order: each expects the state left by the one before
	localparam imc_row_s ROWS[13] = '{
		'{32'h1, 1'h1, 4'hF, 4'h0}, '{32'h1, 1'h1, 4'hF, 4'h0},
		'{32'h10, 1'h1, 4'hF, 4'h0}, '{32'h100, 1'h1, 4'hE, 4'h0},
		'{32'h10, 1'h1, 4'hE, 4'h1}, '{32'hFFFF0008, 1'h1, 4'hE, 4'h1},
		'{32'hE00, 1'h1, 4'h0, 4'h1}, '{32'hE0, 1'h1, 4'h0, 4'hF},
		'{32'h3000, 1'h1, 4'h3, 4'hF}, '{32'hCC00, 1'h1, 4'h3, 4'hF},
		'{32'h2, 1'h0, 4'h3, 4'hF}, '{32'h3, 1'h0, 4'h3, 4'hF},
		'{32'h0, 1'h0, 4'h3, 4'hF}};
	logic        clk;
	logic        rst_b;
	logic [31:0] addr;
	logic [31:0] wdata;
	logic        wr;
	logic        rd;
	logic [31:0] rdata;
	logic        busy;
	logic [3:0]  done;
	logic        en;
	logic        term;
	logic        srst;
	logic [3:0]  watch;
	logic [3:0]  req;
	int          miscompares = 0;
	int          n_tests = 0;

	imc_top #(.NREG(4)) DUT (
		.I_MCLK(clk), .I_RST_B(rst_b), .I_ADDR(addr), .I_WDATA(wdata),
		.I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_REGION_BUSY(busy),
		.I_RECOMP_DONE(done), .O_MON_EN(en), .O_TERMINATE(term),
		.O_SOFT_RESET(srst), .O_WATCH(watch), .O_RECOMP_REQ(req));

	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'h1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'h0;
		#1;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [31:0] a);
		@(posedge clk);
		rd <= 1'h1;
		addr <= a;
		@(posedge clk);
		rd <= 1'h0;
		#1;
	endtask

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ******************
	// main sequence
	// ******************
	initial begin
		{rst_b, wr, rd, busy, done, addr, wdata} = '0;
		repeat (2) @(posedge clk);
		rst_b <= 1'h1;
		#1;
		chk({en, term, srst, watch, req}, 11'h0F0);
		for (int k = 0; k < 13; k++) begin
			wr_reg(`IMC_CMD_ADDR, ROWS[k].d);
			chk({en, watch, req}, {ROWS[k].en, ROWS[k].w, ROWS[k].q});
		end
		@(posedge clk);
		done <= 4'h5;
		@(posedge clk);
		done <= 4'h0;
		#1;
		chk(req, 4'hA);
		wr_reg(`IMC_CMD_ADDR + 32'hC, 32'hF00);
		rd_reg(`IMC_CMD_ADDR);
		chk(rdata, 32'h00000000);
		chk(watch, 4'h3);
		// the refusal of region 0 stays recorded until one status read
		rd_reg(`IMC_STAT_ADDR);
		chk(rdata, 32'h000013A0);
		rd_reg(`IMC_STAT_ADDR);
		chk(rdata, 32'h000003A0);
		wr_reg(`IMC_CMD_ADDR, 32'h1);
		busy <= 1'h1;
		wr_reg(`IMC_CMD_ADDR, 32'h2);
		chk({en, term}, 2'h1);
		@(posedge clk);
		busy <= 1'h0;
		@(posedge clk);
		#1;
		chk(term, 1'h0);
		// a start written while terminating takes effect once busy drops
		wr_reg(`IMC_CMD_ADDR, 32'h1);
		busy <= 1'h1;
		wr_reg(`IMC_CMD_ADDR, 32'h2);
		wr_reg(`IMC_CMD_ADDR, 32'h1);
		chk({en, term}, 2'h1);
		@(posedge clk);
		busy <= 1'h0;
		@(posedge clk);
		#1;
		chk({en, term}, 2'h2);
		wr_reg(`IMC_CMD_ADDR, 32'h4);
		chk({srst, en, watch, req}, 10'h2F0);
		@(posedge clk);
		#1;
		chk(srst, 1'h0);
		test_done;
	end

	// the whole sequence needs well under a thousand cycles
	initial begin
		#50000;
		miscompares++;
		test_done;
	end
endmodule
